// ---- rtl/ptc_core.sv ----
// Functional notes
// - Eight channels: one rx, one tx per peripheral.
// - Moves items to and from memory autonomously.
// - Each channel holds a 32-bit next-address pointer.
// - Each channel holds a 16-bit remaining-items count.
// - One programming covers up to 64k bytes.
// - Controller signals end of transfer to the peripheral when done.
// - Channel registers sit in owning peripheral's window.
// - Each peripheral decodes a 16K window, upper 3M.
// - Control register has set, clear, read addresses.
// - Alias ones change bits, zeros change nothing.
`timescale 1ns/1ps

// ============================================================================
// Eight-channel peripheral transfer controller
// ============================================================================
module ptc_core #(
  parameter int DATA_W     = ptc_pkg::DATA_W,
  parameter int FIFO_DEPTH = ptc_pkg::FIFO_DEPTH
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [31:0]                            paddr,
  input  wire logic [31:0]                            pwdata,
  output logic [31:0]                                 prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic [ptc_pkg::NUM_PERIPH-1:0]              rx_valid,
  input  wire logic [ptc_pkg::NUM_PERIPH-1:0][DATA_W-1:0]  rx_data,
  output logic [ptc_pkg::NUM_PERIPH-1:0]                   rx_ready,
  input  wire logic [ptc_pkg::NUM_PERIPH-1:0]              tx_ready,
  output logic [ptc_pkg::NUM_PERIPH-1:0]                   tx_valid,
  output logic [DATA_W-1:0]                                tx_data,
  output ptc_pkg::ptc_mem_cmd_t                            mem_cmd,
  input  wire logic                                        mem_ack,
  input  wire logic [DATA_W-1:0]                           mem_rdata,
  output logic [ptc_pkg::NUM_PERIPH-1:0]                   end_rx,
  output logic [ptc_pkg::NUM_PERIPH-1:0]                   end_tx
);

  localparam int NP = ptc_pkg::NUM_PERIPH;

  // ==========================================================================
  // State
  // ==========================================================================
  // Pointers and counts of all eight channels plus the sequencer state.
  typedef struct packed {
    logic [NP-1:0][31:0]       rx_ptr;    // Receive next address.
    logic [NP-1:0][15:0]       rx_cnt;    // Receive items left.
    logic [NP-1:0][31:0]       tx_ptr;    // Transmit next address.
    logic [NP-1:0][15:0]       tx_cnt;    // Transmit items left.
    ptc_pkg::ptc_state_t       state;     // Memory port sequencer.
    logic [1:0]                tx_chan;   // Transmit channel being read.
    logic [1:0]                rx_rr;     // Receive round-robin start.
    logic [1:0]                tx_rr;     // Transmit round-robin start.
    logic [31:0]               rdata;     // Captured read data.
    logic [NP-1:0]             tx_vld;    // Transmit item strobe.
    logic [DATA_W-1:0]         tx_dat;    // Transmit item data.
  } ptc_core_state_t;

  ptc_core_state_t s_q;  // Registered state.
  ptc_core_state_t s_d;  // Next state.

  // ==========================================================================
  // Register bus decode
  // ==========================================================================
  logic                         win_hit;     // Address lies in our windows.
  logic [1:0]                   win_idx;     // Which peripheral window.
  logic [ptc_pkg::OFF_W-1:0]    win_off;     // Offset inside the window.
  logic                         reg_ok;      // Offset names a register.
  logic                         wr_acc;      // Write access phase.
  logic [NP-1:0]                ctrl_set_we; // Set alias strobes.
  logic [NP-1:0]                ctrl_clr_we; // Clear alias strobes.
  logic [NP-1:0][ptc_pkg::CTRL_W-1:0] ctrl;  // Enable bits per peripheral.
  logic [31:0]                  rd_mux;      // Read data before capture.

  // Four 16K windows from the base in the upper 3M.
  assign win_hit = (paddr[31:16] == ptc_pkg::PERIPH_BASE[31:16]);
  assign win_idx = paddr[ptc_pkg::WINDOW_SHIFT+1:ptc_pkg::WINDOW_SHIFT];
  assign win_off = paddr[ptc_pkg::OFF_W-1:0];
  assign wr_acc  = psel & penable & pwrite & win_hit & reg_ok;

  // Only the listed offsets answer; anything else reports an error.
  always_comb
  begin
    case (win_off)
      ptc_pkg::OFF_CTRL_SET,
      ptc_pkg::OFF_CTRL_CLR,
      ptc_pkg::OFF_CTRL_VAL,
      ptc_pkg::OFF_STATUS,
      ptc_pkg::OFF_RX_PTR,
      ptc_pkg::OFF_RX_CNT,
      ptc_pkg::OFF_TX_PTR,
      ptc_pkg::OFF_TX_CNT: reg_ok = 1'b1;
      default:             reg_ok = 1'b0;
    endcase
  end

  // Transfers complete in one access phase; errors only in that phase.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(win_hit & reg_ok);
  assign prdata  = s_q.rdata;

  // ==========================================================================
  // Per-peripheral control registers with set and clear aliases
  // ==========================================================================
  for (genvar p = 0; p < NP; p++)
  begin : g_ctrl
    // Each window owns its enable register behind two write aliases.
    assign ctrl_set_we[p] = wr_acc && (win_idx == 2'(p))
                            && (win_off == ptc_pkg::OFF_CTRL_SET);
    assign ctrl_clr_we[p] = wr_acc && (win_idx == 2'(p))
                            && (win_off == ptc_pkg::OFF_CTRL_CLR);

    ptc_alias_reg #(
      .W     (ptc_pkg::CTRL_W),
      .RESET (ptc_pkg::CTRL_RESET)
    ) u_ctrl (
      .clk    (clk),
      .rst    (rst),
      .set_we (ctrl_set_we[p]),
      .clr_we (ctrl_clr_we[p]),
      .wbits  (pwdata[ptc_pkg::CTRL_W-1:0]),
      .value  (ctrl[p])
    );

    // End of transfer is shown while an enabled channel has nothing left.
    assign end_rx[p] = ctrl[p][ptc_pkg::CTRL_RX_EN]
                       & (s_q.rx_cnt[p] == ptc_pkg::CNT_RESET);
    assign end_tx[p] = ctrl[p][ptc_pkg::CTRL_TX_EN]
                       & (s_q.tx_cnt[p] == ptc_pkg::CNT_RESET);
  end

  // Read multiplexer: the aliases read as zero, the value address reads back.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (win_off)
      ptc_pkg::OFF_CTRL_VAL: rd_mux[ptc_pkg::CTRL_W-1:0] = ctrl[win_idx];
      ptc_pkg::OFF_STATUS:
      begin
        rd_mux[ptc_pkg::STAT_RX_END] = end_rx[win_idx];
        rd_mux[ptc_pkg::STAT_TX_END] = end_tx[win_idx];
      end
      ptc_pkg::OFF_RX_PTR:   rd_mux = s_q.rx_ptr[win_idx];
      ptc_pkg::OFF_RX_CNT:   rd_mux[15:0] = s_q.rx_cnt[win_idx];
      ptc_pkg::OFF_TX_PTR:   rd_mux = s_q.tx_ptr[win_idx];
      ptc_pkg::OFF_TX_CNT:   rd_mux[15:0] = s_q.tx_cnt[win_idx];
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Receive selection and write buffer
  // ==========================================================================
  logic                   rx_found;  // Some receive channel may push.
  logic [1:0]             rx_pick;   // Chosen receive channel.
  logic [1:0]             rx_idx;    // Candidate under inspection.
  ptc_pkg::ptc_wr_entry_t fifo_in;   // Item plus destination address.
  ptc_pkg::ptc_wr_entry_t fifo_out;  // Head of the write buffer.
  logic                   fifo_in_ready;  // Buffer has room.
  logic                   fifo_out_valid; // Buffer holds an item.
  logic                   fifo_pop;       // Memory accepted the head.
  logic                   rx_push;        // Item taken from a peripheral.

  // Round-robin search for an enabled receive channel with items left.
  always_comb
  begin
    rx_found = 1'b0;
    rx_pick  = 2'b00;
    rx_idx   = 2'b00;
    for (int k = 0; k < NP; k++)
    begin
      rx_idx = s_q.rx_rr + 2'(k);
      if (!rx_found && rx_valid[rx_idx] && ctrl[rx_idx][ptc_pkg::CTRL_RX_EN]
          && (s_q.rx_cnt[rx_idx] != ptc_pkg::CNT_RESET))
      begin
        rx_found = 1'b1;
        rx_pick  = rx_idx;
      end
    end
  end

  // An item is taken only while the buffer has room.
  always_comb
  begin
    rx_ready = '0;
    rx_ready[rx_pick] = rx_found & fifo_in_ready;
  end

  assign rx_push       = rx_found & fifo_in_ready;
  assign fifo_in.addr  = s_q.rx_ptr[rx_pick];
  assign fifo_in.data  = rx_data[rx_pick];
  assign fifo_pop      = (s_q.state == ptc_pkg::ST_WRITE) & mem_ack;

  ptc_fifo #(
    .WIDTH ($bits(ptc_pkg::ptc_wr_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_found),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // ==========================================================================
  // Transmit selection
  // ==========================================================================
  logic       tx_found;  // Some transmit channel may fetch.
  logic [1:0] tx_pick;   // Chosen transmit channel.
  logic [1:0] tx_idx;    // Candidate under inspection.

  // Round-robin search for a wanted, enabled transmit channel.
  always_comb
  begin
    tx_found = 1'b0;
    tx_pick  = 2'b00;
    tx_idx   = 2'b00;
    for (int k = 0; k < NP; k++)
    begin
      tx_idx = s_q.tx_rr + 2'(k);
      if (!tx_found && tx_ready[tx_idx] && ctrl[tx_idx][ptc_pkg::CTRL_TX_EN]
          && (s_q.tx_cnt[tx_idx] != ptc_pkg::CNT_RESET))
      begin
        tx_found = 1'b1;
        tx_pick  = tx_idx;
      end
    end
  end

  // ==========================================================================
  // Memory command
  // ==========================================================================
  // Writes drain the buffer head; reads use the latched transmit pointer.
  always_comb
  begin
    mem_cmd       = '0;
    mem_cmd.valid = (s_q.state != ptc_pkg::ST_IDLE);
    mem_cmd.write = (s_q.state == ptc_pkg::ST_WRITE);
    if (s_q.state == ptc_pkg::ST_WRITE)
    begin
      mem_cmd.addr  = fifo_out.addr;
      mem_cmd.wdata = fifo_out.data;
    end
    else
    begin
      mem_cmd.addr  = s_q.tx_ptr[s_q.tx_chan];
    end
  end

  assign tx_valid = s_q.tx_vld;
  assign tx_data  = s_q.tx_dat;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Hardware advances come first, so a software write in the same
  // cycle to the same register wins.
  always_comb
  begin
    s_d        = s_q;
    s_d.tx_vld = '0;

    // Capture read data during the setup phase for the access phase.
    if (psel && !penable)
    begin
      s_d.rdata = rd_mux;
    end

    // A receive item enters the buffer with its address fixed now.
    if (rx_push)
    begin
      s_d.rx_ptr[rx_pick] = s_q.rx_ptr[rx_pick] + ptc_pkg::ITEM_STEP;
      s_d.rx_cnt[rx_pick] = s_q.rx_cnt[rx_pick] - ptc_pkg::CNT_STEP;
      s_d.rx_rr           = rx_pick + 2'b01;
    end

    // Sequencer for the single memory port; buffered writes go first.
    case (s_q.state)
      ptc_pkg::ST_IDLE:
      begin
        if (fifo_out_valid)
        begin
          s_d.state = ptc_pkg::ST_WRITE;
        end
        else if (tx_found)
        begin
          s_d.state   = ptc_pkg::ST_READ;
          s_d.tx_chan = tx_pick;
          s_d.tx_rr   = tx_pick + 2'b01;
        end
      end
      ptc_pkg::ST_WRITE:
      begin
        // The buffer head pops on the acknowledge.
        if (mem_ack)
          s_d.state = ptc_pkg::ST_IDLE;
      end
      ptc_pkg::ST_READ:
      begin
        // The fetched item goes out as a one-cycle strobe to its peripheral.
        if (mem_ack)
        begin
          s_d.state              = ptc_pkg::ST_IDLE;
          s_d.tx_dat             = mem_rdata;
          s_d.tx_vld[s_q.tx_chan] = 1'b1;
          s_d.tx_ptr[s_q.tx_chan] = s_q.tx_ptr[s_q.tx_chan]
                                   + ptc_pkg::ITEM_STEP;
          s_d.tx_cnt[s_q.tx_chan] = s_q.tx_cnt[s_q.tx_chan]
                                   - ptc_pkg::CNT_STEP;
        end
      end
      default: s_d.state = ptc_pkg::ST_IDLE;
    endcase

    // Software writes to pointer and count, decoded inside each window.
    if (wr_acc)
    begin
      case (win_off)
        ptc_pkg::OFF_RX_PTR: s_d.rx_ptr[win_idx] = pwdata;
        ptc_pkg::OFF_RX_CNT: s_d.rx_cnt[win_idx] = pwdata[15:0];
        ptc_pkg::OFF_TX_PTR: s_d.tx_ptr[win_idx] = pwdata;
        ptc_pkg::OFF_TX_CNT: s_d.tx_cnt[win_idx] = pwdata[15:0];
        default: s_d.rdata = s_d.rdata;
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset clears pointers, counts and the sequencer.
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule // ptc_core

// ---- rtl/ptc_pkg.sv ----
package ptc_pkg;

  // ==========================================================================
  // Channel organisation
  // ==========================================================================
  // Four served peripherals: three serial ports and one SPI.
  localparam int NUM_PERIPH = 4;
  // One receive and one transmit channel per peripheral.
  localparam int NUM_CHAN   = 2 * NUM_PERIPH;
  // Width of one transferred item.
  localparam int DATA_W     = 16;
  // Depth of the receive write buffer.
  localparam int FIFO_DEPTH = 4;

  // ==========================================================================
  // Peripheral windows
  // ==========================================================================
  // Lowest address of window 0, in the upper 3M bytes.
  localparam logic [31:0] PERIPH_BASE  = 32'hFFFC_0000;
  // Windows span 16K bytes, so the index starts at bit 14.
  localparam int          WINDOW_SHIFT = 14;
  // Offset width inside one window.
  localparam int          OFF_W        = 14;

  // ==========================================================================
  // Register offsets inside each peripheral window
  // ==========================================================================
  localparam logic [OFF_W-1:0] OFF_CTRL_SET = 14'h0000;
  localparam logic [OFF_W-1:0] OFF_CTRL_CLR = 14'h0004;
  localparam logic [OFF_W-1:0] OFF_CTRL_VAL = 14'h0008;
  localparam logic [OFF_W-1:0] OFF_STATUS   = 14'h000C;
  localparam logic [OFF_W-1:0] OFF_RX_PTR   = 14'h0030;
  localparam logic [OFF_W-1:0] OFF_RX_CNT   = 14'h0034;
  localparam logic [OFF_W-1:0] OFF_TX_PTR   = 14'h0038;
  localparam logic [OFF_W-1:0] OFF_TX_CNT   = 14'h003C;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          CTRL_W        = 2;
  localparam int          CTRL_RX_EN    = 0;
  localparam int          CTRL_TX_EN    = 1;
  localparam int          STAT_RX_END   = 0;
  localparam int          STAT_TX_END   = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [31:0] PTR_RESET     = 32'h0000_0000;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  // Pointer advance per item, in bytes.
  localparam logic [31:0] ITEM_STEP     = 32'h0000_0001;
  localparam logic [15:0] CNT_STEP      = 16'h0001;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Memory port sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } ptc_state_t;

  // One command towards the system memory bus.
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [31:0]       addr;
    logic [DATA_W-1:0] wdata;
  } ptc_mem_cmd_t;

  // One buffered receive item with its destination address.
  typedef struct packed {
    logic [31:0]       addr;
    logic [DATA_W-1:0] data;
  } ptc_wr_entry_t;

endpackage

// ---- rtl/ptc_fifo.sv ----
`timescale 1ns/1ps

// ============================================================================
// Small synchronous FIFO with valid/ready on both sides
// ============================================================================
module ptc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // All storage and pointers of the FIFO.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               count;
  } ptc_fifo_state_t;

  ptc_fifo_state_t s_q;   // Registered state.
  ptc_fifo_state_t s_d;   // Next state.
  logic            push;  // Entry accepted this cycle.
  logic            pop;   // Entry removed this cycle.

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next-state logic: write at the tail, read at the head, wrap at DEPTH.
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
    end
    if (pop)
    begin
      s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
    end
    if (push && !pop)
    begin
      s_d.count = s_q.count + CW'(1);
    end
    else if (pop && !push)
    begin
      s_d.count = s_q.count - CW'(1);
    end
  end

  // State register with synchronous reset to empty.
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule // ptc_fifo

// ---- rtl/ptc_alias_reg.sv ----
`timescale 1ns/1ps

// ============================================================================
// Register reached through separate set and clear addresses
// ============================================================================
module ptc_alias_reg #(
  parameter int             W     = 2,
  parameter logic [W-1:0]   RESET = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         set_we,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] wbits,
  output logic [W-1:0]      value
);

  // The whole state is the stored bit vector.
  typedef struct packed {
    logic [W-1:0] bits;
  } ptc_alias_state_t;

  ptc_alias_state_t s_q;  // Registered state.
  ptc_alias_state_t s_d;  // Next state.

  assign value = s_q.bits;

  // Ones set or clear their bit positions, zeros leave them alone.
  always_comb
  begin
    s_d = s_q;
    if (set_we)
    begin
      s_d.bits = s_q.bits | wbits;
    end
    else if (clr_we)
    begin
      s_d.bits = s_q.bits & ~wbits;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q.bits <= RESET;
    else
      s_q <= s_d;
  end

endmodule // ptc_alias_reg

// ---- tb/ptc_core_sva.sv ----
`timescale 1ns/1ps
// ====================
// Port checker of the transfer controller.
module ptc_core_sva (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [31:0]           paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [3:0]            rx_ready,
  input wire logic [3:0]            tx_valid,
  input wire ptc_pkg::ptc_mem_cmd_t mem_cmd,
  input wire logic                  mem_ack,
  input wire logic [3:0]            end_rx
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // A read command answered by memory.
  sequence s_rd_ack;
    mem_cmd.valid && !mem_cmd.write && mem_ack;
  endsequence
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_outside; psel && penable && paddr[31:16] != 16'hFFFC |-> pslverr; endproperty
  a_outside: assert property (p_outside) else $error("outside access accepted");
  property p_onehot; $onehot0(rx_ready); endproperty
  a_onehot: assert property (p_onehot) else $error("two receive takes");
  property p_end_stop; (rx_ready & end_rx) == 4'h0; endproperty
  a_end_stop: assert property (p_end_stop) else $error("take at count zero");
  property p_tx_pulse; tx_valid != 4'h0 |=> tx_valid == 4'h0; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("long tx strobe");
  property p_hold; mem_cmd.valid && !mem_ack |=> $stable(mem_cmd); endproperty
  a_hold: assert property (p_hold) else $error("command moved");
  property p_gap; mem_cmd.valid && mem_ack |=> !mem_cmd.valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle after answer");
  property p_tx_after; s_rd_ack |=> $onehot(tx_valid); endproperty
  a_tx_after: assert property (p_tx_after) else $error("read not delivered");
  property p_tx_cause; tx_valid != 4'h0 |-> $past(mem_ack); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx without read");
endmodule // ptc_core_sva

bind ptc_core ptc_core_sva i_sva (.clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
  .rx_ready, .tx_valid, .mem_cmd, .mem_ack, .end_rx);

// ---- tb/ptc_mem_model.sv ----
`timescale 1ns/1ps
// ====================
// Memory acks after lat cycles; reads return addr xor 5A5A.
module ptc_mem_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ptc_pkg::ptc_mem_cmd_t cmd,
  input  wire logic [4:0]            lat,
  output logic                       ack,
  output logic [15:0]                rdata,
  output logic [31:0]                wr_addr,
  output logic [15:0]                wr_data
);
  logic [4:0] wait_q; // Cycles spent on the current command.
  initial rdata = 16'h0000;
  // Read data toggles off its answer cycle so stale data looks wrong.
  always @(posedge clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst)
      wait_q <= 5'h00;
    else if (cmd.valid && !ack && wait_q >= lat)
    begin
      ack <= 1'b1;
      wait_q <= 5'h00;
      rdata <= cmd.addr[15:0] ^ 16'h5A5A;
      if (cmd.write)
      begin
        wr_addr <= cmd.addr;
        wr_data <= cmd.wdata;
      end
    end
    else if (cmd.valid && !ack)
      wait_q <= wait_q + 5'h01;
  end
endmodule // ptc_mem_model

// ---- tb/test_ptc_core.sv ----
`timescale 1ns/1ps
// ====================
// Self-checking bench of the transfer controller.
module test_ptc_core;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, slv_q, mem_ack;
  logic [31:0] paddr, pwdata, prdata, rd_q, wr_addr;
  logic [3:0] rx_valid, rx_ready, tx_ready, tx_valid, end_rx, end_tx;
  logic [3:0][15:0] rx_data;
  logic [15:0] tx_data, mem_rdata, wr_data;
  logic [4:0] lat;
  ptc_pkg::ptc_mem_cmd_t mem_cmd;
  int err_count = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  ptc_core i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_valid, .rx_data, .rx_ready, .tx_ready, .tx_valid, .tx_data, .mem_cmd,
    .mem_ack, .mem_rdata, .end_rx, .end_tx);
  ptc_mem_model i_mem (.clk(clk), .rst(rst), .cmd(mem_cmd), .lat(lat), .ack(mem_ack),
    .rdata(mem_rdata), .wr_addr(wr_addr), .wr_data(wr_data));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Address of offset off in window p.
  function automatic logic [31:0] adr(input int p, input logic [13:0] off);
    return ptc_pkg::PERIPH_BASE | (32'(p) << ptc_pkg::WINDOW_SHIFT) | 32'(off);
  endfunction
  // One zero-wait transfer; read data to rd_q, error to slv_q.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    #1 slv_q = pslverr;
    rd_q = prdata;
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask
  // Reset value, widths, unmapped offset, foreign address.
  task automatic t_regs;
    apb(1'b0, adr(3, ptc_pkg::OFF_TX_PTR), '0);
    check("ptr_rst", rd_q, ptc_pkg::PTR_RESET);
    apb(1'b1, adr(3, ptc_pkg::OFF_TX_PTR), 32'hDEAD_BEEF);
    apb(1'b0, adr(3, ptc_pkg::OFF_TX_PTR), '0);
    check("tx_ptr", rd_q, 32'hDEAD_BEEF);
    check("slverr", slv_q, 1'b0);
    apb(1'b1, adr(3, ptc_pkg::OFF_TX_CNT), 32'hABCD_FFFF);
    apb(1'b0, adr(3, ptc_pkg::OFF_TX_CNT), '0);
    check("tx_cnt", rd_q, 32'h0000_FFFF);
    apb(1'b1, adr(1, 14'h0100), '0);
    check("unmapped", slv_q, 1'b1);
    apb(1'b0, 32'h0000_0030, '0);
    check("outside", slv_q, 1'b1);
  endtask
  // Aliases change only the bits written as one.
  task automatic t_alias;
    apb(1'b1, adr(1, ptc_pkg::OFF_CTRL_SET), 32'h0000_0003);
    apb(1'b1, adr(1, ptc_pkg::OFF_CTRL_CLR), 32'h0000_0001);
    apb(1'b1, adr(1, ptc_pkg::OFF_CTRL_SET), '0);
    apb(1'b0, adr(1, ptc_pkg::OFF_CTRL_VAL), '0);
    check("ctrl_val", rd_q, 32'h0000_0002);
    check("end_tx1", end_tx[1], 1'b1);
    apb(1'b0, adr(1, ptc_pkg::OFF_CTRL_SET), '0);
    check("set_read", rd_q, '0);
    apb(1'b1, adr(1, ptc_pkg::OFF_CTRL_CLR), 32'h0000_0002);
  endtask
  // Eight rx items, slow memory: buffer fills, refuses, drains.
  task automatic t_rx;
    int acc;
    acc = 0;
    lat = 5'h14;
    apb(1'b1, adr(0, ptc_pkg::OFF_RX_PTR), 32'h0000_0100);
    apb(1'b1, adr(0, ptc_pkg::OFF_RX_CNT), 32'h0000_0008);
    apb(1'b1, adr(0, ptc_pkg::OFF_CTRL_SET), 32'h0000_0001);
    for (int i = 0; i < 400 && acc < 8; i++)
    begin
      @(negedge clk);
      rx_valid[0] = 1'b1;
      rx_data[0] = 16'h1000 + 16'(acc);
      #1 if (rx_ready[0] === 1'b1) acc++;
      if (i == 12) check("full", rx_ready[0], 1'b0);
    end
    @(negedge clk);
    rx_valid[0] = 1'b0;
    for (int i = 0; i < 400 && wr_addr !== 32'h0000_0107; i++) @(negedge clk);
    check("wr_data", wr_data, 32'h0000_1007);
    apb(1'b0, adr(0, ptc_pkg::OFF_RX_PTR), '0);
    check("rx_ptr", rd_q, 32'h0000_0108);
    check("end_rx0", end_rx[0], 1'b1);
  endtask
  // Two tx items fetched and strobed to peripheral 2.
  task automatic t_tx;
    int n;
    logic [15:0] d;
    n = 0;
    lat = 5'h03;
    apb(1'b1, adr(2, ptc_pkg::OFF_TX_PTR), 32'h0000_0200);
    apb(1'b1, adr(2, ptc_pkg::OFF_TX_CNT), 32'h0000_0002);
    apb(1'b1, adr(2, ptc_pkg::OFF_CTRL_SET), 32'h0000_0002);
    for (int i = 0; i < 200 && n < 2; i++)
    begin
      @(negedge clk);
      if (tx_valid[2] === 1'b1)
      begin
        n++;
        d = tx_data;
      end
    end
    check("tx_data", d, 32'h0000_585B);
    apb(1'b0, adr(2, ptc_pkg::OFF_TX_PTR), '0);
    check("tx_ptr2", rd_q, 32'h0000_0202);
    apb(1'b0, adr(2, ptc_pkg::OFF_STATUS), '0);
    check("status", rd_q, 32'h0000_0002);
    check("end_tx2", end_tx[2], 1'b1);
  endtask
  initial
  begin
    #40000;
    err_count++;
    finish_test();
  end
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_valid = '0;
    rx_data = '0;
    tx_ready = 4'hF;
    lat = 5'h00;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_alias();
    t_rx();
    t_tx();
    finish_test();
  end
endmodule // test_ptc_core
